// ---- hdl/audio_dma_pkg.sv ----
// Constants and carrier types for the audio serial DMA and status block
package audio_dma_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] DMA_CTRL_OFS = 8'h00;
  localparam logic [7:0] REC_BASE_OFS = 8'h08;
  localparam logic [7:0] REC_LEN_OFS = 8'h0C;
  localparam logic [7:0] REC_CUR_OFS = 8'h10;
  localparam logic [7:0] PLAY_BASE_OFS = 8'h14;
  localparam logic [7:0] PLAY_LEN_OFS = 8'h18;
  localparam logic [7:0] PLAY_CUR_OFS = 8'h1C;
  localparam logic [7:0] REC_STAT_OFS = 8'h20;
  localparam logic [7:0] PLAY_STAT_OFS = 8'h24;
  localparam logic [7:0] SER_CTRL_OFS = 8'h28;
  localparam logic [7:0] DOWN_CNT_OFS = 8'h2C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FLAG_SECTION = 0;
  localparam int FLAG_UNDER = 1;
  localparam int FLAG_OVER = 2;
  localparam int FLAG_DETECT = 3;
  localparam int FLAG_CNT_ZERO = 4;
  localparam int SN_LSB = 5;
  localparam int REC_SEL_LSB = 14;
  localparam int PLAY_SEL_LSB = 12;
  localparam int CNT_EN_BIT = 4;
  localparam int DETECT_EN_BIT = 3;
  localparam int SLAVE_BIT = 20;
  localparam int PRS_LSB = 16;
  localparam int BCLK_DIV_LSB = 5;
  localparam int MCLK_SEL_BIT = 4;
  localparam int FORMAT_BIT = 3;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [31:0] DOWN_CNT_RESET = 32'hFFFF_FFFF;
  localparam logic [31:0] ADDR_STEP = 32'h0000_0004;
  localparam logic [4:0] BITS_PER_CHANNEL_M1 = 5'h1F;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [23:0] left;
    logic [23:0] right;
  } stereo_pair_t;

  typedef struct packed {
    logic push;
    logic full;
    logic pop;
    logic empty;
  } fifo_events_t;

endpackage

// ---- hdl/audio_serial_dma_status.sv ----
// Audio serial DMA ring addressing, event status and serial clocking
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/10ps

module dma_ring
  import audio_dma_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [31:0] base,
  input wire logic [31:0] len,
  input wire logic [1:0] sel,
  input wire logic beat,
  output logic [31:0] addr_q,
  output logic [2:0] sn_q,
  output logic hit
);
  logic [31:0] offset_q;
  logic [31:0] off_next;
  logic wrap;
  logic [34:0] lhs;
  logic [34:0] rhs;

  assign off_next = offset_q + ADDR_STEP;
  assign wrap = off_next >= len;
  assign lhs = {3'h0, off_next} << sel;
  assign rhs = {3'h0, len} * ({32'h0, sn_q} + 35'h1);
  assign hit = beat & (wrap | ((sel != 2'h0) & (lhs >= rhs)));

  // ----------------------------------------------------------------
  // Ring offset and section number
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      offset_q <= REG_RESET;
      sn_q <= 3'h0;
    end
    else if (beat)
    begin
      if (wrap)
      begin
        offset_q <= REG_RESET;
        sn_q <= 3'h0;
      end
      else
      begin
        offset_q <= off_next;
        if (hit)
          sn_q <= sn_q + 3'h1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      addr_q <= REG_RESET;
    else
      addr_q <= base + offset_q;
  end
endmodule

module audio_serial_dma_status
  import audio_dma_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rec_dma_beat,
  input wire logic play_dma_beat,
  output logic [31:0] rec_dma_addr,
  output logic [31:0] play_dma_addr,
  input wire fifo_events_t rec_fifo,
  input wire fifo_events_t play_fifo,
  input wire stereo_pair_t play_pair,
  output logic play_pair_taken,
  output stereo_pair_t rec_pair,
  output logic rec_pair_valid,
  output logic mclk_o,
  output logic bclk_o,
  output logic bclk_oe,
  input wire logic bclk_i,
  output logic lrclk_o,
  output logic lrclk_oe,
  input wire logic lrclk_i,
  output logic sdo_o,
  input wire logic sdi_i
);
  logic [31:0] ctrl_q, rec_base_q, rec_len_q, play_base_q, play_len_q, ser_q, down_q;
  logic [4:0] rec_flag_q, play_flag_q;
  logic [2:0] rec_sn, play_sn;
  logic rec_hit, play_hit;
  logic ack_q;
  logic [31:0] wmask, rd_d;
  logic wr_ok;
  logic [4:0] rec_set, play_set, rec_clr, play_clr;

  // ----------------------------------------------------------------
  // DMA rings
  // ----------------------------------------------------------------
  dma_ring u_rec_ring (
    .clk(clk),
    .sys_rst(sys_rst),
    .base(rec_base_q),
    .len(rec_len_q),
    .sel(ctrl_q[REC_SEL_LSB +: 2]),
    .beat(rec_dma_beat),
    .addr_q(rec_dma_addr),
    .sn_q(rec_sn),
    .hit(rec_hit)
  );

  dma_ring u_play_ring (
    .clk(clk),
    .sys_rst(sys_rst),
    .base(play_base_q),
    .len(play_len_q),
    .sel(ctrl_q[PLAY_SEL_LSB +: 2]),
    .beat(play_dma_beat),
    .addr_q(play_dma_addr),
    .sn_q(play_sn),
    .hit(play_hit)
  );

  // ----------------------------------------------------------------
  // Avalon slave: one wait cycle, then answer
  // ----------------------------------------------------------------
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign wr_ok = avs_write & ack_q;
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ack_q <= 1'b0;
    else
      ack_q <= (avs_read | avs_write) & ~ack_q;
  end

  always_comb
  begin
    case (avs_address)
      DMA_CTRL_OFS: rd_d = ctrl_q;
      REC_BASE_OFS: rd_d = rec_base_q;
      REC_LEN_OFS: rd_d = rec_len_q;
      REC_CUR_OFS: rd_d = rec_dma_addr;
      PLAY_BASE_OFS: rd_d = play_base_q;
      PLAY_LEN_OFS: rd_d = play_len_q;
      PLAY_CUR_OFS: rd_d = play_dma_addr;
      REC_STAT_OFS: rd_d = {24'h0, rec_sn, 2'h0, rec_flag_q[2:0]};
      PLAY_STAT_OFS: rd_d = {24'h0, play_sn, play_flag_q};
      SER_CTRL_OFS: rd_d = ser_q;
      DOWN_CNT_OFS: rd_d = down_q;
      default: rd_d = REG_RESET;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      avs_readdata <= REG_RESET;
    else if (avs_read & ~ack_q)
      avs_readdata <= rd_d;
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctrl_q <= REG_RESET;
      rec_base_q <= REG_RESET;
      rec_len_q <= REG_RESET;
      play_base_q <= REG_RESET;
      play_len_q <= REG_RESET;
      ser_q <= REG_RESET;
    end
    else if (wr_ok)
    begin
      case (avs_address)
        DMA_CTRL_OFS: ctrl_q <= merge(ctrl_q, avs_writedata, wmask);
        REC_BASE_OFS: rec_base_q <= merge(rec_base_q, avs_writedata, wmask);
        REC_LEN_OFS: rec_len_q <= merge(rec_len_q, avs_writedata, wmask);
        PLAY_BASE_OFS: play_base_q <= merge(play_base_q, avs_writedata, wmask);
        PLAY_LEN_OFS: play_len_q <= merge(play_len_q, avs_writedata, wmask);
        SER_CTRL_OFS: ser_q <= merge(ser_q, avs_writedata, wmask);
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Clock generation: PLL stand-in is clk/2, then prescaler
  // ----------------------------------------------------------------
  logic pll_q, pll_rise, mclk_q, mclk_tick;
  logic [4:0] pre_cnt_q, div_m1;
  logic [2:0] bdiv_q;
  logic bclk_q, lr_q, master;
  logic [4:0] mbit_q;

  assign master = ~ser_q[SLAVE_BIT];

  always_comb
  begin
    case (ser_q[PRS_LSB +: 4])
      4'h9: div_m1 = 5'h09;
      4'hB: div_m1 = 5'h0B;
      4'hD: div_m1 = 5'h0D;
      4'hF: div_m1 = 5'h0F;
      default: div_m1 = {2'h0, ser_q[PRS_LSB +: 3]};
    endcase
  end

  assign pll_rise = ~pll_q;
  assign mclk_tick = pll_rise & (pre_cnt_q == div_m1);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pll_q <= 1'b0;
      pre_cnt_q <= 5'h0;
      mclk_q <= 1'b0;
    end
    else
    begin
      pll_q <= ~pll_q;
      if (pll_rise)
        pre_cnt_q <= (pre_cnt_q >= div_m1) ? 5'h0 : pre_cnt_q + 5'h1;
      if (ser_q[MCLK_SEL_BIT])
        mclk_q <= pll_rise;
      else if (div_m1[0])
        mclk_q <= pll_rise & (pre_cnt_q <= {1'b0, div_m1[4:1]}) |
                  ~pll_rise & mclk_q;
      else
        // Odd factors: one high clk cycle per period, half a PLL period
        mclk_q <= pll_rise & (pre_cnt_q == 5'h0);
    end
  end

  assign mclk_o = mclk_q;

  // Master bit clock toggles every (divider + 1) prescaler periods, also when the master clock runs at the PLL rate
  logic bclk_rise_m, bclk_fall_m;
  assign bclk_fall_m = master & mclk_tick & (bdiv_q == ser_q[BCLK_DIV_LSB +: 3]) & bclk_q;
  assign bclk_rise_m = master & mclk_tick & (bdiv_q == ser_q[BCLK_DIV_LSB +: 3]) & ~bclk_q;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      bdiv_q <= 3'h0;
      bclk_q <= 1'b0;
      lr_q <= 1'b0;
      mbit_q <= 5'h0;
    end
    else if (master & mclk_tick)
    begin
      if (bdiv_q >= ser_q[BCLK_DIV_LSB +: 3])
      begin
        bdiv_q <= 3'h0;
        bclk_q <= ~bclk_q;
        if (bclk_q)
        begin
          mbit_q <= mbit_q + 5'h1;
          if (mbit_q == BITS_PER_CHANNEL_M1)
            lr_q <= ~lr_q;
        end
      end
      else
        bdiv_q <= bdiv_q + 3'h1;
    end
  end

  assign bclk_o = bclk_q;
  assign lrclk_o = lr_q;
  assign bclk_oe = master;
  assign lrclk_oe = master;

  // ----------------------------------------------------------------
  // Slave pin synchronisers: three stages, level changes on agreement
  // ----------------------------------------------------------------
  logic [2:0] bsync_q, lsync_q;
  logic bclk_f_q, lr_f_q;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      bsync_q <= 3'h0;
      lsync_q <= 3'h0;
      bclk_f_q <= 1'b0;
      lr_f_q <= 1'b0;
    end
    else
    begin
      bsync_q <= {bsync_q[1:0], bclk_i};
      lsync_q <= {lsync_q[1:0], lrclk_i};
      if (bsync_q[1] == bsync_q[2])
        bclk_f_q <= bsync_q[2];
      if (lsync_q[1] == lsync_q[2])
        lr_f_q <= lsync_q[2];
    end
  end

  logic bclk_rise_s, bclk_fall_s, brise, bfall, lr_now, lr_pin_now;
  assign bclk_rise_s = ~master & (bsync_q[1] == bsync_q[2]) & bsync_q[2] & ~bclk_f_q;
  assign bclk_fall_s = ~master & (bsync_q[1] == bsync_q[2]) & ~bsync_q[2] & bclk_f_q;
  assign brise = bclk_rise_m | bclk_rise_s;
  assign bfall = bclk_fall_m | bclk_fall_s;
  // Frame level as it stands after this fall, so a channel starts on the frame edge itself
  assign lr_pin_now = (lsync_q[1] == lsync_q[2]) ? lsync_q[2] : lr_f_q;
  assign lr_now = master ? (lr_q ^ (mbit_q == BITS_PER_CHANNEL_M1)) : lr_pin_now;

  // ----------------------------------------------------------------
  // Serial data path
  // ----------------------------------------------------------------
  logic lr_last_q, ch_start, sent_q;
  logic [31:0] tx_q, rx_q;
  stereo_pair_t cur_q;
  logic [23:0] tx_word;
  assign ch_start = bfall & (lr_now != lr_last_q);
  assign tx_word = lr_now ? cur_q.right : play_pair.left;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      lr_last_q <= 1'b0;
      tx_q <= REG_RESET;
      sdo_o <= 1'b0;
      cur_q <= '0;
      play_pair_taken <= 1'b0;
      sent_q <= 1'b0;
    end
    else
    begin
      play_pair_taken <= ch_start & ~lr_now;
      sent_q <= ch_start;
      if (bfall)
      begin
        lr_last_q <= lr_now;
        if (ch_start)
        begin
          if (ser_q[FORMAT_BIT])
            tx_q <= {tx_word, 8'h00};
          else
            tx_q <= {1'b0, tx_word, 7'h00};
          sdo_o <= ser_q[FORMAT_BIT] ? tx_word[23] : 1'b0;
          if (~lr_now)
            cur_q <= play_pair;
        end
        else
        begin
          tx_q <= {tx_q[30:0], 1'b0};
          sdo_o <= tx_q[30];
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rx_q <= REG_RESET;
      rec_pair <= '0;
      rec_pair_valid <= 1'b0;
    end
    else
    begin
      rec_pair_valid <= ch_start & ~lr_now;
      if (ch_start)
      begin
        if (lr_now)
          rec_pair.left <= ser_q[FORMAT_BIT] ? rx_q[31:8] : rx_q[30:7];
        else
          rec_pair.right <= ser_q[FORMAT_BIT] ? rx_q[31:8] : rx_q[30:7];
        rx_q <= REG_RESET;
      end
      else if (brise)
        rx_q <= {rx_q[30:0], sdi_i};
    end
  end

  // ----------------------------------------------------------------
  // Down-counter and playback data detector
  // ----------------------------------------------------------------
  logic det_hit;
  stereo_pair_t prev_q;
  assign det_hit = ctrl_q[DETECT_EN_BIT] & play_pair_taken &
                   ((cur_q == '0) | (cur_q.left[23] != prev_q.left[23]) |
                    (cur_q.right[23] != prev_q.right[23]));

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      prev_q <= '0;
    else if (play_pair_taken)
      prev_q <= cur_q;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      down_q <= DOWN_CNT_RESET;
    else if (wr_ok & (avs_address == DOWN_CNT_OFS))
      down_q <= merge(down_q, avs_writedata, wmask);
    else if (ctrl_q[CNT_EN_BIT] & sent_q & (down_q != REG_RESET))
      down_q <= down_q - 32'h1;
  end

  // ----------------------------------------------------------------
  // Sticky event flags
  // ----------------------------------------------------------------
  assign rec_set = {2'b00, rec_fifo.push & rec_fifo.full,
                    rec_fifo.pop & rec_fifo.empty, rec_hit};
  assign play_set = {ctrl_q[CNT_EN_BIT] & (down_q == REG_RESET), det_hit,
                     play_fifo.push & play_fifo.full,
                     play_fifo.pop & play_fifo.empty, play_hit};
  assign rec_clr = (wr_ok & (avs_address == REC_STAT_OFS) & avs_byteenable[0]) ?
                   avs_writedata[4:0] : 5'h0;
  assign play_clr = (wr_ok & (avs_address == PLAY_STAT_OFS) & avs_byteenable[0]) ?
                    avs_writedata[4:0] : 5'h0;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rec_flag_q <= 5'h0;
      play_flag_q <= 5'h0;
    end
    else
    begin
      rec_flag_q <= rec_set | (rec_flag_q & ~rec_clr);
      play_flag_q <= play_set | (play_flag_q & ~play_clr);
    end
  end
endmodule

// ---- testbench/audio_dma_chk.sv ----
// Assertion checker for the audio serial DMA and status block
`timescale 1ns/10ps
module audio_dma_chk
  import audio_dma_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire logic rec_dma_beat,
  input wire logic [31:0] rec_dma_addr,
  input wire logic mclk_o,
  input wire logic bclk_o,
  input wire logic bclk_oe,
  input wire logic lrclk_oe
);
  // --------
  // Shadow of serial control
  // --------
  logic [31:0] ser_q;
  logic [5:0] age_q;
  logic ser_wr;
  logic steady;
  assign ser_wr = avs_write && !avs_waitrequest && avs_address == SER_CTRL_OFS;
  assign steady = age_q == 6'h3F && !ser_q[MCLK_SEL_BIT];
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ser_q <= REG_RESET;
    else if (ser_wr)
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (avs_byteenable[i])
          ser_q[8*i +: 8] <= avs_writedata[8*i +: 8];
      end
    end
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst || ser_wr)
      age_q <= 6'h00;
    else if (age_q != 6'h3F)
      age_q <= age_q + 6'h01;
  end
  // --------
  // Properties
  // --------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  chk_single_wait: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  chk_wait_first: assert property (
    $rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("bus answer without wait");
  chk_role_enable: assert property (
    bclk_oe == !ser_q[SLAVE_BIT] && lrclk_oe == bclk_oe)
    else $error("clock enables wrong for role");
  chk_addr_cause: assert property (
    $changed(rec_dma_addr) |-> $past(rec_dma_beat, 2) || $past(avs_write, 2))
    else $error("record address moved without cause");
  chk_pll_bypass: assert property (
    age_q == 6'h3F && ser_q[MCLK_SEL_BIT] |-> mclk_o != $past(mclk_o))
    else $error("master clock not at pll rate");
  chk_even_divide: assert property (
    disable iff (sys_rst || ser_wr)
    $rose(mclk_o) && steady && ser_q[19:16] == 4'h1 |-> mclk_o [*2] ##1 !mclk_o [*2])
    else $error("master clock divide by two wrong");
  chk_odd_high: assert property (
    disable iff (sys_rst || ser_wr)
    $rose(mclk_o) && steady && ser_q[19:16] == 4'h2 |=> !mclk_o [*5] ##1 mclk_o)
    else $error("master clock divide by three wrong");
  chk_bit_clock: assert property (
    disable iff (sys_rst || ser_wr)
    $rose(bclk_o) && steady && bclk_oe && ser_q[19:16] == 4'h1 && ser_q[7:5] == 3'h1
    |-> bclk_o [*8] ##1 !bclk_o [*8])
    else $error("bit clock rate wrong");
  cover property ($rose(mclk_o) && steady && ser_q[19:16] == 4'h2);
  cover property (rec_dma_beat ##1 rec_dma_beat);
  cover property ($fell(bclk_oe));
endmodule

bind audio_serial_dma_status audio_dma_chk chk_i (
  .clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
  .avs_waitrequest, .rec_dma_beat, .rec_dma_addr, .mclk_o, .bclk_o, .bclk_oe, .lrclk_oe
);

// ---- testbench/audio_codec_model.sv ----
// Behavioural audio codec on the serial pins
`timescale 1ns/10ps
module audio_codec_model
#(
  parameter logic [23:0] LEFT_WORD = 24'hC3A581,
  parameter logic [23:0] RIGHT_WORD = 24'h5A1E69
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic bclk_o,
  input wire logic bclk_oe,
  input wire logic lrclk_o,
  input wire logic lrclk_oe,
  input wire logic sdo_o,
  output logic bclk_i,
  output logic lrclk_i,
  output logic sdi_i,
  output logic [23:0] heard_left
);
  logic bw;
  logic lw;
  logic bq;
  logic lq;
  logic [1:0] div_q;
  logic [4:0] slot_q;
  logic [5:0] pos_q;
  logic [5:0] np;
  logic [31:0] sh_q;
  assign bw = bclk_oe ? bclk_o : bclk_i;
  assign lw = lrclk_oe ? lrclk_o : lrclk_i;
  assign np = (lw != lq) ? 6'h00 : pos_q + 6'h01;
  // Slave clocks run only while the block is slave
  always_ff @(posedge clk)
  begin
    if (sys_rst || bclk_oe)
    begin
      div_q <= 2'h0;
      bclk_i <= 1'b0;
      lrclk_i <= 1'b0;
      slot_q <= 5'h00;
    end
    else
    begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h3)
      begin
        bclk_i <= !bclk_i;
        slot_q <= bclk_i ? slot_q + 5'h01 : slot_q;
        if (bclk_i && slot_q == 5'h1F)
          lrclk_i <= !lrclk_i;
      end
    end
  end
  // Data leaves on falling bit clock, MSB one bit after frame change
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      bq <= 1'b0;
      lq <= 1'b0;
      pos_q <= 6'h00;
      sdi_i <= 1'b0;
      sh_q <= 32'h0;
      heard_left <= 24'h0;
    end
    else
    begin
      bq <= bw;
      // Block's serial output shifts in on rising bit clock; left word kept at frame edge
      if (!bq && bw)
        sh_q <= {sh_q[30:0], sdo_o};
      if (bq && !bw)
      begin
        lq <= lw;
        pos_q <= np;
        if (lw && !lq)
          heard_left <= sh_q[30:7];
        if (np >= 6'h01 && np <= 6'h18)
          sdi_i <= lw ? RIGHT_WORD[6'h18 - np] : LEFT_WORD[6'h18 - np];
        else
          sdi_i <= !sdi_i;
      end
    end
  end
endmodule

// ---- testbench/audio_serial_dma_status_test.sv ----
// Self-checking bench for the audio serial DMA and status block
`timescale 1ns/10ps
module audio_serial_dma_status_test
  import audio_dma_pkg::*;
;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic rec_dma_beat = 1'b0;
  logic play_dma_beat = 1'b0;
  logic [31:0] rec_dma_addr;
  logic [31:0] play_dma_addr;
  fifo_events_t rec_fifo = 4'h0;
  fifo_events_t play_fifo = 4'h0;
  stereo_pair_t play_pair = 48'h123456_654321;
  stereo_pair_t rec_pair;
  logic play_pair_taken, rec_pair_valid, mclk_o, bclk_o, bclk_oe, bclk_i;
  logic lrclk_o, lrclk_oe, lrclk_i, sdo_o, sdi_i;
  logic [23:0] heard_left;
  int bad_count = 0;
  int checked = 0;
  int n;
  logic [31:0] q;
  logic [7:0] ofs [9] = '{8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28};
  logic [31:0] ser_v [3] = '{32'h0001_0020, 32'h0002_0000, 32'h0000_0010};

  always #10 clk = !clk;

  audio_serial_dma_status dut (
    .clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .rec_dma_beat, .play_dma_beat, .rec_dma_addr,
    .play_dma_addr, .rec_fifo, .play_fifo, .play_pair, .play_pair_taken, .rec_pair,
    .rec_pair_valid, .mclk_o, .bclk_o, .bclk_oe, .bclk_i, .lrclk_o, .lrclk_oe, .lrclk_i,
    .sdo_o, .sdi_i
  );
  audio_codec_model codec (
    .clk, .sys_rst, .bclk_o, .bclk_oe, .lrclk_o, .lrclk_oe, .sdo_o, .bclk_i, .lrclk_i, .sdi_i,
    .heard_left
  );

  // --------
  // Tasks
  // --------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out;
    if (bad_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (avs_waitrequest !== 1'b0 && k < 50);
    q = avs_readdata;
    if (k >= 50)
      bad_count++;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = ALL);
    xfer(1'b0, a, 32'h0);
    check($sformatf("reg %h", a), q & m, e);
  endtask
  task automatic beats(input logic rec, input int cnt);
    repeat (cnt)
    begin
      rec_dma_beat <= rec;
      play_dma_beat <= !rec;
      @(posedge clk);
    end
    rec_dma_beat <= 1'b0;
    play_dma_beat <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic ev(input fifo_events_t r, input fifo_events_t p);
    rec_fifo <= r;
    play_fifo <= p;
    @(posedge clk);
    rec_fifo <= 4'h0;
    play_fifo <= 4'h0;
    @(posedge clk);
  endtask
  task automatic wait_pair;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rec_pair_valid !== 1'b1 && n < 3000);
    if (n >= 3000)
      bad_count++;
  endtask

  // --------
  // Tests
  // --------
  initial
  begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    foreach (ofs[i])
      rc(ofs[i], 32'h0);
    rc(DOWN_CNT_OFS, ALL);
    wr(REC_BASE_OFS, 32'h0000_1000);
    wr(REC_LEN_OFS, 32'h0000_0040);
    wr(PLAY_BASE_OFS, 32'h0000_2000);
    wr(PLAY_LEN_OFS, 32'h0000_0040);
    wr(REC_CUR_OFS, ALL);
    wr(8'h3C, ALL);
    rc(REC_BASE_OFS, 32'h0000_1000);
    rc(PLAY_BASE_OFS, 32'h0000_2000);
    rc(REC_LEN_OFS, 32'h0000_0040);
    rc(REC_CUR_OFS, 32'h0000_1000);
    rc(PLAY_CUR_OFS, 32'h0000_2000);
    rc(8'h3C, 32'h0);
    for (int c = 0; c < 4; c++)
    begin
      wr(DMA_CTRL_OFS, 32'h0000_3000 | 32'(c << REC_SEL_LSB));
      wr(REC_STAT_OFS, 32'h7);
      n = (c == 0) ? 16 : 16 >> c;
      beats(1'b1, n);
      rc(REC_STAT_OFS, (c == 0) ? 32'h01 : 32'h21, 32'hFF);
      rc(REC_CUR_OFS, 32'h1000 + 32'((4 * n) & 63));
      beats(1'b1, 16 - n);
      rc(REC_STAT_OFS, 32'h01, 32'hFF);
    end
    wr(REC_STAT_OFS, 32'h0);
    rc(REC_STAT_OFS, 32'h01, 32'hFF);
    wr(REC_STAT_OFS, 32'h1);
    rc(REC_STAT_OFS, 32'h00, 32'hFF);
    beats(1'b0, 2);
    rc(PLAY_STAT_OFS, 32'h21, 32'hFF);
    rc(PLAY_CUR_OFS, 32'h0000_2008);
    beats(1'b0, 14);
    rc(PLAY_STAT_OFS, 32'h01, 32'hFF);
    wr(REC_STAT_OFS, 32'h7);
    wr(PLAY_STAT_OFS, 32'h7);
    ev(4'hA, 4'h5);
    rc(REC_STAT_OFS, 32'h0, 32'h7);
    rc(PLAY_STAT_OFS, 32'h0, 32'h7);
    ev(4'hC, 4'h3);
    rc(REC_STAT_OFS, 32'h4, 32'h7);
    rc(PLAY_STAT_OFS, 32'h2, 32'h7);
    ev(4'h3, 4'hC);
    rc(REC_STAT_OFS, 32'h6, 32'h7);
    rc(PLAY_STAT_OFS, 32'h6, 32'h7);
    fork
      wr(REC_STAT_OFS, 32'h4);
      begin
        @(posedge clk);
        rec_fifo <= 4'hC;
        @(posedge clk);
        rec_fifo <= 4'h0;
      end
    join
    rc(REC_STAT_OFS, 32'h6, 32'h7);
    wr(REC_STAT_OFS, 32'h6);
    rc(REC_STAT_OFS, 32'h0, 32'h7);
    foreach (ser_v[i])
    begin
      wr(SER_CTRL_OFS, ser_v[i]);
      rc(SER_CTRL_OFS, ser_v[i]);
      repeat (150) @(posedge clk);
    end
    wr(SER_CTRL_OFS, 32'h0);
    wr(DOWN_CNT_OFS, 32'h3);
    wr(PLAY_STAT_OFS, 32'h1F);
    wr(DMA_CTRL_OFS, 32'h0000_F010);
    repeat (1000) @(posedge clk);
    rc(DOWN_CNT_OFS, 32'h0);
    rc(PLAY_STAT_OFS, 32'h10, 32'h18);
    play_pair <= 48'h0;
    wr(DMA_CTRL_OFS, 32'h0000_F008);
    repeat (600) @(posedge clk);
    rc(PLAY_STAT_OFS, 32'h08, 32'h08);
    play_pair <= 48'h400000_000001;
    repeat (600) @(posedge clk);
    wr(PLAY_STAT_OFS, 32'h08);
    repeat (600) @(posedge clk);
    rc(PLAY_STAT_OFS, 32'h00, 32'h08);
    play_pair <= 48'h800000_000001;
    repeat (600) @(posedge clk);
    rc(PLAY_STAT_OFS, 32'h08, 32'h08);
    check("sdo left", {8'h0, heard_left}, 32'h0080_0000);
    wr(SER_CTRL_OFS, 32'h0010_0000);
    check("bclk_oe", {31'h0, bclk_oe}, 32'h0);
    wait_pair;
    wait_pair;
    wait_pair;
    check("rec left", {8'h0, rec_pair.left}, 32'h00C3_A581);
    check("rec right", {8'h0, rec_pair.right}, 32'h005A_1E69);
    close_out;
  end

  initial
  begin
    repeat (40000) @(posedge clk);
    bad_count++;
    close_out;
  end
endmodule
